// ---- hw/mode_reg_ctl.sv ----
// controller end: apb slave issuing register commands
`timescale 1ns/1ns
module mode_reg_ctl
  import mode_reg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  mode_reg_if.ctl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [2:0] {st_idle, st_issue, st_wait_rd, st_post_reset, st_off} state_t;
  state_t state_r;
  logic [7:0] ma_r, wd_r, rd_r;
  logic rd_mode_r, cke_r, done_r;
  logic [1:0] cmd_r;
  logic [7:0] ma_out_r, op_out_r;
  logic [cnt_w-1:0] wait_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic acc, commit, wr_acc, rd_acc, go, busy, mapped, ma_listed;
  logic [7:0] op_mask;
  logic [1:0] wr_code;
  logic [31:0] rd_mux;

  // apb decode, answers one cycle into the access phase; writes land at the completing edge
  assign acc = psel && penable && !pready_r;
  assign commit = psel && penable && pready_r;
  assign wr_acc = commit && pwrite;
  assign rd_acc = acc && !pwrite;
  assign busy = state_r != st_idle && state_r != st_off;
  assign go = wr_acc && paddr == apb_ctrl && pwdata[ctrl_go_bit] && !busy;
  assign mapped = paddr == apb_ctrl || paddr == apb_addr || paddr == apb_wdata
    || paddr == apb_status || paddr == apb_rdata;
  assign rd_mux = paddr == apb_addr ? {24'h0, ma_r} :
    paddr == apb_wdata ? {24'h0, wd_r} :
    paddr == apb_status ? {29'h0, state_r == st_off, done_r, busy} :
    paddr == apb_rdata ? {24'h0, rd_r} : 32'h0;

  // outgoing write data loses its reserved bits; wholly reserved addresses get a nop
  assign op_mask = ma_r == ma_feat_one ? feat_one_mask :
    ma_r == ma_feat_two ? feat_two_mask :
    ma_r == ma_io_cfg ? io_cfg_mask :
    ma_r == ma_term ? term_mask : ~zero8;
  assign ma_listed = ma_r inside {ma_dev_info, ma_feat_one, ma_feat_two, ma_io_cfg, ma_temp, ma_maker,
    ma_rev_one, ma_rev_two, ma_width, ma_test, ma_cal, ma_term, ma_bank_mask, ma_seg_mask, ma_dq_a,
    ma_dq_b, ma_ca_entry_main, ma_ca_exit, ma_ca_entry_aux, ma_reset};
  assign wr_code = ma_listed ? cmd_write : cmd_nop; // R14

  // apb answer registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc && !mapped;
      prdata_r <= rd_acc ? rd_mux : 32'h0;
    end
  end

  // software-held address and data
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ma_r <= zero8;
      wd_r <= zero8;
    end else begin
      if (wr_acc && paddr == apb_addr) ma_r <= pwdata[7:0];
      if (wr_acc && paddr == apb_wdata) wd_r <= pwdata[7:0];
    end
  end

  // command sequencer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= st_idle;
      cke_r <= 1'b1;
      cmd_r <= cmd_nop;
      ma_out_r <= zero8;
      op_out_r <= zero8;
      rd_mode_r <= 1'b0;
      done_r <= 1'b0;
      rd_r <= zero8;
      wait_r <= '0;
    end else begin
      cmd_r <= cmd_nop;
      unique case (state_r)
        st_idle: begin
          if (wr_acc && paddr == apb_ctrl && pwdata[ctrl_off_bit]) begin
            state_r <= st_off;
            cke_r <= 1'b0; // R04
          end else if (go && pwdata[ctrl_rst_bit]) begin
            cmd_r <= cmd_write; // R01
            ma_out_r <= ma_reset;
            op_out_r <= zero8;
            wait_r <= cnt_w'(post_reset_cycles);
            done_r <= 1'b0;
            state_r <= st_post_reset;
          end else if (go) begin
            rd_mode_r <= pwdata[ctrl_rd_bit];
            done_r <= 1'b0;
            state_r <= st_issue;
          end
        end
        st_issue: begin
          cmd_r <= rd_mode_r ? cmd_read : wr_code; // R06
          ma_out_r <= ma_r;
          op_out_r <= wd_r & op_mask; // R11
          if (rd_mode_r) begin
            state_r <= st_wait_rd;
          end else begin
            done_r <= 1'b1;
            state_r <= st_idle;
          end
        end
        st_wait_rd: begin
          if (link.rd_valid) begin
            rd_r <= link.dq_o;
            done_r <= 1'b1;
            state_r <= st_idle;
          end
        end
        st_post_reset: begin
          cke_r <= 1'b1; // R02
          if (wait_r == '0) begin
            done_r <= 1'b1;
            state_r <= st_idle;
          end else begin
            wait_r <= wait_r - 1'b1;
          end
        end
        st_off: begin
          cke_r <= 1'b0; // R04
          if (wr_acc && paddr == apb_ctrl && !pwdata[ctrl_off_bit]) begin
            cke_r <= 1'b1;
            state_r <= st_idle;
          end
        end
      endcase
    end
  end

  assign link.cke = cke_r;
  assign link.cmd = cmd_r;
  assign link.ma = ma_out_r;
  assign link.op = op_out_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule

// ---- hw/mode_reg_dev.sv ----
// device end: mode register file answering register commands
`timescale 1ns/1ns
module mode_reg_dev
  import mode_reg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  mode_reg_if.dev link,
  output logic [7:0] feat_one,
  output logic [7:0] feat_two,
  output logic [7:0] io_cfg,
  output logic [7:0] term_cfg,
  output logic [7:0] bank_mask,
  output logic [7:0] seg_mask,
  output logic auto_init_busy
);
  logic [7:0] feat_one_r, feat_two_r, io_cfg_r, term_r, bank_r, seg_r;
  logic [cnt_w-1:0] init_cnt_r;
  logic busy_r;
  logic [7:0] dq_r;
  logic dq_oe_n_r, dqs_oe_n_r, dqs_t_r, rdv_r;
  logic active, is_wr, is_rd, rst_cmd;
  logic [7:0] op_clean;
  logic [7:0] rd_val;
  logic [7:0] dev_info;

  // commands only act while clock enable is high
  assign active = link.cke;
  assign is_wr = active && link.cmd == cmd_write; // R06
  assign is_rd = active && link.cmd == cmd_read; // R06
  assign rst_cmd = is_wr && link.ma == ma_reset;
  assign dev_info = {low_latency_option, wl_set_b_support, 1'b0, cal_pin_self_test, 2'b00, busy_r}; // R08 R03

  // read decode: readable classes, others junk
  always_comb begin
    unique case (link.ma)
      ma_dev_info: rd_val = dev_info & dev_info_mask; // R12
      ma_temp: rd_val = temp_val & temp_mask; // R12
      ma_maker: rd_val = maker_id_val;
      ma_rev_one: rd_val = rev_one_val;
      ma_rev_two: rd_val = rev_two_val;
      ma_width: rd_val = width_val;
      ma_dq_a: rd_val = dq_a_val;
      ma_dq_b: rd_val = dq_b_val;
      default: rd_val = junk8; // R13 R16 R07
    endcase
  end

  assign op_clean = link.op;

  // writable registers; read-only and unmapped writes ignored
  always_ff @(posedge clk_sys) begin
    if (!nrst || rst_cmd) begin
      feat_one_r <= feat_one_rst;
      feat_two_r <= feat_two_rst;
      io_cfg_r <= zero8;
      term_r <= zero8;
      bank_r <= zero8;
      seg_r <= zero8;
    end else if (is_wr) begin
      unique case (link.ma)
        ma_feat_one: feat_one_r <= op_clean & feat_one_mask; // R09
        ma_feat_two: feat_two_r <= op_clean & feat_two_mask; // R10
        ma_io_cfg: io_cfg_r <= op_clean & io_cfg_mask;
        ma_term: term_r <= op_clean & term_mask;
        ma_bank_mask: bank_r <= op_clean;
        ma_seg_mask: seg_r <= op_clean;
        default: ; // R15 R16 R07
      endcase
    end
  end

  // auto-initialization timer started by reset command
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_r <= 1'b1;
      init_cnt_r <= cnt_w'(auto_init_cycles);
    end else if (rst_cmd) begin
      busy_r <= 1'b1; // R03
      init_cnt_r <= cnt_w'(auto_init_cycles);
    end else if (init_cnt_r != '0) begin
      init_cnt_r <= init_cnt_r - 1'b1;
    end else begin
      busy_r <= 1'b0; // R03
    end
  end

  // read answer: data and strobe driven one cycle, released when cke low
  always_ff @(posedge clk_sys) begin
    if (!nrst || !active) begin
      dq_r <= zero8;
      dq_oe_n_r <= 1'b1; // R05
      dqs_oe_n_r <= 1'b1; // R05
      dqs_t_r <= 1'b0;
      rdv_r <= 1'b0;
    end else begin
      dq_r <= is_rd ? rd_val : zero8;
      dq_oe_n_r <= !is_rd;
      dqs_oe_n_r <= !is_rd; // R13
      dqs_t_r <= is_rd;
      rdv_r <= is_rd;
    end
  end

  assign link.dq_o = dq_r;
  assign link.dq_oe_n = dq_oe_n_r;
  assign link.dqs_t_o = dqs_t_r;
  assign link.dqs_c_o = !dqs_t_r;
  assign link.dqs_oe_n = dqs_oe_n_r;
  assign link.rd_valid = rdv_r;
  assign feat_one = feat_one_r;
  assign feat_two = feat_two_r;
  assign io_cfg = io_cfg_r;
  assign term_cfg = term_r;
  assign bank_mask = bank_r;
  assign seg_mask = seg_r;
  assign auto_init_busy = busy_r;
endmodule

// ---- hw/mode_reg_if.sv ----
// link between the controller and the mode register file
`timescale 1ns/1ns
interface mode_reg_if;
  logic cke;
  logic [1:0] cmd;
  logic [7:0] ma;
  logic [7:0] op;
  logic [7:0] dq_o;
  logic dq_oe_n;
  logic dqs_t_o;
  logic dqs_c_o;
  logic dqs_oe_n;
  logic rd_valid;
  modport ctl (output cke, output cmd, output ma, output op,
    input dq_o, input dq_oe_n, input dqs_t_o, input dqs_c_o, input dqs_oe_n, input rd_valid);
  modport dev (input cke, input cmd, input ma, input op,
    output dq_o, output dq_oe_n, output dqs_t_o, output dqs_c_o, output dqs_oe_n, output rd_valid);
endinterface

// ---- hw/mode_reg_pkg.sv ----
// shared constants for the mode register file and its controller
// Notes on behaviour
// R01: reset command restarts init after idle point
// R02: after reset, clock enable high, nops
// R03: auto-init status bit reads 1 while busy
// R04: clock enable held low during power-off
// R05: outputs high impedance while clock enable low
// R06: reads and writes only by register commands
// R07: each register honours its access class
// R08: device info holds latency, self-test, status
// R09: feature one holds recovery, burst fields
// R10: feature two holds leveling, latency fields
// R11: controller writes reserved bits as zero
// R12: reserved bits read back as zero
// R13: write-only reads give junk, strobe toggles
// R14: never write wholly reserved addresses
// R15: writes to read-only registers change nothing
// R16: unmapped addresses decode as reserved
package mode_reg_pkg;
  localparam int unsigned clk_mhz = 125;
  localparam int unsigned post_reset_ns = 1000;
  localparam int unsigned post_reset_cycles = (post_reset_ns * clk_mhz + 999) / 1000;
  localparam int unsigned auto_init_ns = 10000;
  localparam int unsigned auto_init_cycles = (auto_init_ns * clk_mhz) / 1000;
  localparam int unsigned cnt_w = 16;
  localparam logic [7:0] ma_dev_info = 8'h00;
  localparam logic [7:0] ma_feat_one = 8'h01;
  localparam logic [7:0] ma_feat_two = 8'h02;
  localparam logic [7:0] ma_io_cfg = 8'h03;
  localparam logic [7:0] ma_temp = 8'h04;
  localparam logic [7:0] ma_maker = 8'h05;
  localparam logic [7:0] ma_rev_one = 8'h06;
  localparam logic [7:0] ma_rev_two = 8'h07;
  localparam logic [7:0] ma_width = 8'h08;
  localparam logic [7:0] ma_test = 8'h09;
  localparam logic [7:0] ma_cal = 8'h0a;
  localparam logic [7:0] ma_term = 8'h0b;
  localparam logic [7:0] ma_bank_mask = 8'h10;
  localparam logic [7:0] ma_seg_mask = 8'h11;
  localparam logic [7:0] ma_dq_a = 8'h20;
  localparam logic [7:0] ma_dq_b = 8'h28;
  localparam logic [7:0] ma_ca_entry_main = 8'h29;
  localparam logic [7:0] ma_ca_exit = 8'h2a;
  localparam logic [7:0] ma_ca_entry_aux = 8'h30;
  localparam logic [7:0] ma_reset = 8'h3f;
  // field masks (reserved bits cleared): writable registers, then temperature and device info reads
  localparam logic [7:0] feat_one_mask = 8'hef;
  localparam logic [7:0] feat_two_mask = 8'hdf;
  localparam logic [7:0] io_cfg_mask = 8'h0f;
  localparam logic [7:0] term_mask = 8'h07;
  localparam logic [7:0] temp_mask = 8'h87;
  localparam logic [7:0] dev_info_mask = 8'hd9;
  localparam logic [7:0] feat_one_rst = 8'h83;
  localparam logic [7:0] feat_two_rst = 8'h00;
  localparam logic [7:0] zero8 = 8'h00;
  localparam logic [7:0] junk8 = 8'ha5;
  // device capability and identity values (arbitrary)
  localparam logic [7:0] maker_id_val = 8'h5a;
  localparam logic [7:0] rev_one_val = 8'h01;
  localparam logic [7:0] rev_two_val = 8'h02;
  localparam logic [7:0] width_val = 8'h18;
  localparam logic [7:0] temp_val = 8'h03;
  localparam logic [7:0] dq_a_val = 8'h55;
  localparam logic [7:0] dq_b_val = 8'h3c;
  localparam logic low_latency_option = 1'b0;
  localparam logic wl_set_b_support = 1'b1;
  localparam logic [1:0] cal_pin_self_test = 2'b11;
  localparam logic [1:0] cmd_nop = 2'b00;
  localparam logic [1:0] cmd_read = 2'b01;
  localparam logic [1:0] cmd_write = 2'b10;
  // controller apb register offsets
  localparam logic [7:0] apb_ctrl = 8'h00;
  localparam logic [7:0] apb_addr = 8'h04;
  localparam logic [7:0] apb_wdata = 8'h08;
  localparam logic [7:0] apb_status = 8'h0c;
  localparam logic [7:0] apb_rdata = 8'h10;
  localparam int unsigned ctrl_go_bit = 0;
  localparam int unsigned ctrl_rd_bit = 1;
  localparam int unsigned ctrl_rst_bit = 2;
  localparam int unsigned ctrl_off_bit = 3;
endpackage

// ---- sim/mode_reg_props.sv ----
// checker watching the link between controller and register file
`timescale 1ns/1ns
module mode_reg_props
  import mode_reg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cke,
  input wire logic [1:0] cmd,
  input wire logic [7:0] ma,
  input wire logic [7:0] op,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe_n,
  input wire logic dqs_t_o,
  input wire logic dqs_c_o,
  input wire logic dqs_oe_n,
  input wire logic rd_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // a read command is taken only while cke is high
  wire rd_go = cke && cmd == cmd_read;
  wire wo_hit = ma inside {ma_feat_one, ma_feat_two, ma_io_cfg, ma_term, ma_reset};
  wire wr_go = cke && cmd == cmd_write;
  // writable bits of the addressed register; reserved bits must go out as zero
  wire [7:0] op_keep = ma == ma_feat_one ? feat_one_mask : ma == ma_feat_two ? feat_two_mask :
    ma == ma_io_cfg ? io_cfg_mask : ma == ma_term ? term_mask : 8'hff;
  wire ma_known = ma inside {ma_dev_info, ma_feat_one, ma_feat_two, ma_io_cfg, ma_temp, ma_maker,
    ma_rev_one, ma_rev_two, ma_width, ma_test, ma_cal, ma_term, ma_bank_mask, ma_seg_mask, ma_dq_a,
    ma_dq_b, ma_ca_entry_main, ma_ca_exit, ma_ca_entry_aux, ma_reset};
  wire ma_readable = ma inside {ma_dev_info, ma_temp, ma_maker, ma_rev_one, ma_rev_two, ma_width,
    ma_dq_a, ma_dq_b};
  // answers, strobes and data contents
  a_read_answer: assert property (rd_go |=> rd_valid && !dq_oe_n)
    else $error("read command got no answer");
  a_answer_cause: assert property (rd_valid |-> $past(rd_go))
    else $error("read data without a read command");
  a_strobe_pair: assert property (rd_valid |-> !dqs_oe_n && dqs_t_o != dqs_c_o)
    else $error("strobe pair not driven with read data");
  a_info_zeros: assert property (rd_go && ma == ma_dev_info |=> (dq_o & ~dev_info_mask) == zero8)
    else $error("device info reserved bits not zero");
  a_temp_zeros: assert property (rd_go && ma == ma_temp |=> (dq_o & ~temp_mask) == zero8)
    else $error("temperature reserved bits not zero");
  a_wo_junk: assert property (rd_go && wo_hit |=> dq_o == junk8)
    else $error("write-only read not junk");
  a_gap_junk: assert property (rd_go && !ma_readable |=> dq_o == junk8)
    else $error("unreadable register read not junk");
  a_rsvd_written: assert property (wr_go |-> (op & ~op_keep) == zero8)
    else $error("reserved bits written as one");
  a_no_gap_write: assert property (wr_go |-> ma_known)
    else $error("write to a wholly reserved address");
  a_reset_quiet: assert property (cke && cmd == cmd_write && ma == ma_reset |=> (cke && cmd == cmd_nop)[*8])
    else $error("command too soon after reset");
  a_off_release: assert property (!cke ##1 !cke |-> dq_oe_n && dqs_oe_n)
    else $error("outputs driven while cke low");
  // main scenarios
  c_info: cover property (rd_go && ma == ma_dev_info);
  c_reset: cover property (cke && cmd == cmd_write && ma == ma_reset);
  c_off: cover property (!cke ##1 !cke);
endmodule

// ---- sim/sdram_mode_register_map_test.sv ----
// bench driving the controller over apb against the register file
`timescale 1ns/1ns
module sdram_mode_register_map_test
  import mode_reg_pkg::*;
;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, busy, err;
  logic [7:0] paddr, f1, f2, io, tm, bm, sm;
  logic [31:0] pwdata, prdata, rd;
  int bad_count = 0;
  int compares = 0;
  // both ends joined through the link
  mode_reg_if mode_reg_if_inst();
  mode_reg_ctl mode_reg_ctl_inst(.clk_sys(clk_sys), .nrst(nrst), .link(mode_reg_if_inst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  mode_reg_dev mode_reg_dev_inst(.clk_sys(clk_sys), .nrst(nrst), .link(mode_reg_if_inst), .feat_one(f1),
    .feat_two(f2), .io_cfg(io), .term_cfg(tm), .bank_mask(bm), .seg_mask(sm), .auto_init_busy(busy));
  mode_reg_props mode_reg_props_inst(.clk_sys(clk_sys), .nrst(nrst), .cke(mode_reg_if_inst.cke),
    .cmd(mode_reg_if_inst.cmd), .ma(mode_reg_if_inst.ma), .op(mode_reg_if_inst.op),
    .dq_o(mode_reg_if_inst.dq_o), .dq_oe_n(mode_reg_if_inst.dq_oe_n), .dqs_t_o(mode_reg_if_inst.dqs_t_o),
    .dqs_c_o(mode_reg_if_inst.dqs_c_o), .dqs_oe_n(mode_reg_if_inst.dqs_oe_n),
    .rd_valid(mode_reg_if_inst.rd_valid));
  // free-running system clock
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    $display("compares %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task stop;
    bad_count++;
    end_of_test();
  endtask
  // one apb transfer; setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      stop();
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // one link command: c=1 write, 3 read, 5 reset; rd holds read data
  task mr(input logic [31:0] c, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1, apb_addr, {24'h0, a});
    apb(1, apb_wdata, {24'h0, d});
    apb(1, apb_ctrl, c);
    do begin
      apb(0, apb_status, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    if (n >= 300)
      stop();
    apb(0, apb_rdata, 0);
  endtask
  task wait_init;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000)
      stop();
  endtask
  task t_info;
    chk("busy", busy, 1);
    mr(3, ma_dev_info, 0);
    chk("info busy", rd[0], 1);
    wait_init();
    mr(3, ma_dev_info, 0);
    chk("info", rd, {24'h0, low_latency_option, wl_set_b_support, 1'b0, cal_pin_self_test, 3'h0});
  endtask
  task t_write;
    mr(1, ma_feat_one, 8'h7b);
    chk("feat one", f1, 8'h6b);
    mr(1, ma_feat_two, 8'he7);
    chk("feat two", f2, 8'hc7);
    mr(1, ma_io_cfg, 8'h0a);
    chk("io", io, 8'h0a);
    mr(1, ma_term, 8'h05);
    chk("term", tm, 8'h05);
    mr(1, ma_bank_mask, 8'h81);
    chk("bank", bm, 8'h81);
    mr(1, ma_seg_mask, 8'h7e);
    chk("seg", sm, 8'h7e);
    mr(3, ma_feat_two, 0);
    chk("wo read", rd, junk8);
    mr(3, 8'h0c, 0);
    chk("gap read", rd, junk8);
    mr(1, 8'h0c, 8'h33);
    chk("gap write", f2, 8'hc7);
  endtask
  task t_ro;
    logic [7:0] ra[7] = '{ma_maker, ma_rev_one, ma_rev_two, ma_width, ma_dq_a, ma_dq_b, ma_temp};
    logic [7:0] ex[7] = '{maker_id_val, rev_one_val, rev_two_val, width_val, dq_a_val, dq_b_val, temp_val};
    for (int i = 0; i < 7; i++) begin
      mr(1, ra[i], 8'h00);
      mr(3, ra[i], 0);
      chk("ro read", rd, ex[i]);
      chk("ro keeps", f1, 8'h6b);
    end
  endtask
  task t_reset;
    mr(5, ma_reset, 0);
    chk("rst one", f1, feat_one_rst);
    chk("rst two", f2, feat_two_rst);
    chk("rst busy", busy, 1);
    wait_init();
  endtask
  task t_off;
    apb(1, apb_ctrl, 32'h8);
    apb(0, apb_status, 0);
    chk("off flag", rd[2], 1);
    chk("cke", mode_reg_if_inst.cke, 0);
    chk("dq oe", mode_reg_if_inst.dq_oe_n, 1);
    chk("dqs oe", mode_reg_if_inst.dqs_oe_n, 1);
    apb(1, apb_ctrl, 0);
    apb(0, 8'h20, 0);
    chk("slverr", err, 1);
    chk("bad rd", rd, 0);
  endtask
  // reset, then the scenarios in turn
  initial begin
    nrst = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1;
    @(posedge clk_sys);
    t_info();
    t_write();
    t_ro();
    t_reset();
    t_off();
    end_of_test();
  end
endmodule
